// File: inc/itc_defs.vh
// Purpose: Constants for the interrupt and trap control block
// Assumes: Internal I/O addresses are 8 bits wide
// Notes:   Included by hw/itc_cpu_irq_trap.v
`ifndef ITC_DEFS_VH
`define ITC_DEFS_VH

// Internal I/O addresses
`define ITC_ADDR_VECTOR_LOW   8'h33
`define ITC_ADDR_CONTROL      8'h34

// Control register fields
`define ITC_BIT_UNDEF_FLAG    7
`define ITC_BIT_FETCH_POS     6
`define ITC_BIT_EN_LEVEL2     2
`define ITC_BIT_EN_LEVEL1     1
`define ITC_BIT_EN_LEVEL0     0

// Reset values
`define ITC_RST_VECTOR_LOW    3'h0
`define ITC_RST_VECTOR_HIGH   8'h00
`define ITC_RST_ENABLES       3'h1

// Fixed low vector codes
`define ITC_CODE_LEVEL1       5'h00
`define ITC_CODE_LEVEL2       5'h02

// Restart addresses
`define ITC_TRAP_ADDR         16'h0000
`define ITC_NMI_ADDR          16'h0066
`define ITC_MODE1_ADDR        16'h0038

// Level-0 response modes
`define ITC_MODE0             2'h0
`define ITC_MODE1             2'h1
`define ITC_MODE2             2'h2

// Source codes, priority order
`define ITC_SRC_NONE          4'h0
`define ITC_SRC_TRAP          4'h1
`define ITC_SRC_NMI           4'h2
`define ITC_SRC_LEVEL0        4'h3
`define ITC_SRC_LEVEL1        4'h4
`define ITC_SRC_LEVEL2        4'h5
`define ITC_SRC_ONCHIP0       4'h6

`endif

// File: hw/itc_cpu_irq_trap.v
// What this block does
// [RULE1] Vector low byte: bits 7-5 from vector-low register, 4-0 fixed code.
// [RULE2] Reset clears the vector-low register to zero.
// [RULE3] Vector-low at I/O 33H, written and read by internal I/O; low bits unstored.
// [RULE4] Fetching an undefined opcode sets the undefined-opcode flag, bit 7.
// [RULE5] Writing 0 clears that flag; writing 1 leaves it.
// [RULE6] Bit 6 read-only: 0 second byte trapped, 1 third byte.
// [RULE7] Control bits 2,1,0 enable level-2,1,0 inputs; 0 masks.
// [RULE8] Global enable 0 refuses all maskable sources; NMI and trap unaffected.
// [RULE9] Disable clears both enable flags; enable sets both.
// [RULE10] NMI acceptance copies global into saved, then clears global.
// [RULE11] Return-from-NMI copies saved into global; saved unchanged.
// [RULE12] Maskable acceptance clears both flags; interrupt return and trap do not.
// [RULE13] Reset clears both enable flags.
// [RULE14] Load-from-vector-high or refresh copies enable state to parity/overflow.
// [RULE15] Trap on undefined opcode in normal fetch or level-0 mode-0 acknowledge.
// [RULE16] Trap: set flag, push PC of bad opcode, restart at 0000H.
// [RULE17] No bus release, refresh, DMA or wait right after the trap state.
// [RULE18] Four external inputs; level-0 has three selectable response modes.
// [RULE19] Vector-high register is the table high byte; reset to zero.
// [RULE20] Fixed priority: trap, NMI, level 0,1,2, then eight on-chip sources.
// [RULE21] NMI falling edge; acceptance clears DMA enable, stacks PC, goes 0066H.
// [RULE22] Fixed codes: 00000 for level 1, 00010 for level 2.
// [RULE23] Register writes and flag updates take effect on the ending clock edge.
//
// Purpose: Interrupt and trap control of an 8-bit CPU core
// Assumes: Sequencer pulses instruction and accept strobes for one cycle
// Notes:   On-chip sources arrive already masked by their own peripheral registers
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.vh"

module itc_cpu_irq_trap #(
    parameter ONCHIP_COUNT = 8
) (
    // Clock and reset
    input  wire                    clk,
    input  wire                    rst,
    // External interrupt pins, active low
    input  wire                    nmiIn_n,
    input  wire                    ext_irq_level0_n,
    input  wire                    ext_irq_level1_n,
    input  wire                    ext_irq_level2_n,
    // On-chip requests, index 0 highest priority
    input  wire [ONCHIP_COUNT-1:0] onchipReq,
    // Internal I/O port
    input  wire [7:0]              ioAddr,
    input  wire [7:0]              ioWrData,
    input  wire                    internal_io_write_instr,
    input  wire                    internal_io_read_instr,
    output reg  [7:0]              ioRdData,
    // Instruction strobes from the sequencer
    input  wire                    enable_interrupts_instr,
    input  wire                    disable_interrupts_instr,
    input  wire                    return_from_nonmaskable,
    input  wire                    return_from_interrupt,
    input  wire                    load_acc_from_vector_high,
    input  wire                    load_acc_from_refresh,
    input  wire                    loadVectorHigh,
    input  wire [7:0]              accData,
    input  wire [1:0]              setMode,
    input  wire                    setModeStrobe,
    // Fetch reporting
    input  wire                    undefOpcode,
    input  wire                    undefThirdByte,
    input  wire                    ackLevel0Cycle,
    // Acceptance handshake
    input  wire                    acceptStrobe,
    // Outputs to the sequencer
    output reg                     irqPending,
    output reg  [3:0]              irqSource,
    output reg  [15:0]             vectorAddr,
    output reg                     vectorIsTable,
    output reg                     trapRequest,
    output reg                     trap_state,
    output reg                     trapNoInsert,
    output reg                     parityFromEnable,
    output reg                     parityStrobe,
    output reg                     dmaMainEnableClear,
    output reg                     global_irq_enable,
    output reg                     saved_irq_enable,
    output reg  [7:0]              vectorHigh,
    output reg  [1:0]              level0Mode
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Pins idle high, so reset loads ones and no false request follows reset
    reg  [3:0] pinMeta;
    reg  [3:0] pinSync;
    reg        nmiPrev;
    reg        nmiLatched;

    always @(posedge clk) begin
        if (rst) begin
            pinMeta <= 4'hf;
            pinSync <= 4'hf;
        end else begin
            pinMeta <= {nmiIn_n, ext_irq_level2_n, ext_irq_level1_n, ext_irq_level0_n};
            pinSync <= pinMeta;
        end
    end

    // [RULE21] NMI edge latch
    // The edge is held until accepted, so short pulses are not lost
    always @(posedge clk) begin
        if (rst) begin
            nmiPrev    <= 1'b1;
            nmiLatched <= 1'b0;
        end else begin
            nmiPrev <= pinSync[3];
            if (nmiPrev && !pinSync[3])
                nmiLatched <= 1'b1;
            else if (acceptStrobe && irqSource == `ITC_SRC_NMI)
                nmiLatched <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [2:0] vectorLowBase;    // vector_low_base bits 7-5
    reg        undefFlag;
    reg        fetchBytePos;
    reg  [2:0] extEnable;        // level2, level1, level0

    // [RULE23] Writes land on the edge ending the I/O cycle
    // Decoded straight from the strobe, so a read issued right after a write
    // already sees the new value one edge later
    wire wrVecLow  = internal_io_write_instr && ioAddr == `ITC_ADDR_VECTOR_LOW;
    wire wrControl = internal_io_write_instr && ioAddr == `ITC_ADDR_CONTROL;

    // [RULE15] Trap causes
    // Level-0 mode-0 acknowledge fetches an instruction, so it can trap too
    wire trapEvent = undefOpcode &&
                     (!ackLevel0Cycle || level0Mode == `ITC_MODE0);

    // [RULE2] [RULE3] Vector-low storage, only bits 7-5 kept
    always @(posedge clk) begin
        if (rst)
            vectorLowBase <= `ITC_RST_VECTOR_LOW;
        else if (wrVecLow)
            vectorLowBase <= ioWrData[7:5];
    end

    // [RULE19] Vector-high register
    always @(posedge clk) begin
        if (rst)
            vectorHigh <= `ITC_RST_VECTOR_HIGH;
        else if (loadVectorHigh)
            vectorHigh <= accData;
    end

    // [RULE18] Level-0 mode select, mode 0 after reset
    always @(posedge clk) begin
        if (rst)
            level0Mode <= `ITC_MODE0;
        else if (setModeStrobe && setMode != 2'h3)
            level0Mode <= setMode;
    end

    // [RULE4] [RULE5] Undefined-opcode flag
    // Set wins over a simultaneous software clear
    always @(posedge clk) begin
        if (rst)
            undefFlag <= 1'b0;
        else if (trapEvent)
            undefFlag <= 1'b1;
        else if (wrControl && !ioWrData[`ITC_BIT_UNDEF_FLAG])
            undefFlag <= 1'b0;
    end

    // [RULE6] Fetch byte position, hardware only
    always @(posedge clk) begin
        if (rst)
            fetchBytePos <= 1'b0;
        else if (trapEvent)
            fetchBytePos <= undefThirdByte;
    end

    // [RULE7] Per-input enables
    always @(posedge clk) begin
        if (rst)
            extEnable <= `ITC_RST_ENABLES;
        else if (wrControl)
            extEnable <= ioWrData[2:0];
    end

    // [RULE3] Read back; unstored bits read zero
    always @(posedge clk) begin
        if (rst)
            ioRdData <= 8'h00;
        else if (internal_io_read_instr && ioAddr == `ITC_ADDR_VECTOR_LOW)
            ioRdData <= {vectorLowBase, 5'h00};
        else if (internal_io_read_instr && ioAddr == `ITC_ADDR_CONTROL)
            ioRdData <= {undefFlag, fetchBytePos, 3'h0, extEnable};
        else
            ioRdData <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority resolution
    // [RULE8] Maskable sources gated by global enable
    wire lvl0Req = !pinSync[0] && extEnable[`ITC_BIT_EN_LEVEL0] && global_irq_enable;
    wire lvl1Req = !pinSync[1] && extEnable[`ITC_BIT_EN_LEVEL1] && global_irq_enable;
    wire lvl2Req = !pinSync[2] && extEnable[`ITC_BIT_EN_LEVEL2] && global_irq_enable;
    wire [ONCHIP_COUNT-1:0] chipReq = onchipReq & {ONCHIP_COUNT{global_irq_enable}};

    reg  [3:0]  next_source;
    reg  [4:0]  chipCode;
    reg  [15:0] next_vector;
    reg         next_table;
    integer     k;

    // [RULE20] Fixed priority encoder
    // Loop runs downward so the lowest index, the highest priority, wins last
    always @* begin
        next_source = `ITC_SRC_NONE;
        chipCode    = 5'h00;
        for (k = ONCHIP_COUNT - 1; k >= 0; k = k - 1) begin
            if (chipReq[k]) begin
                next_source = `ITC_SRC_ONCHIP0 + k[3:0];
                chipCode    = 5'h04 + {k[2:0], 1'b0} + {4'h0, k[3]};
            end
        end
        if (lvl2Req)
            next_source = `ITC_SRC_LEVEL2;
        if (lvl1Req)
            next_source = `ITC_SRC_LEVEL1;
        if (lvl0Req)
            next_source = `ITC_SRC_LEVEL0;
        if (nmiLatched)
            next_source = `ITC_SRC_NMI;
    end

    // [RULE1] [RULE22] Vector address forming
    always @* begin
        next_vector = 16'h0000;
        next_table  = 1'b0;
        case (next_source)
            `ITC_SRC_NMI:
                next_vector = `ITC_NMI_ADDR;
            `ITC_SRC_LEVEL0: begin
                next_vector = (level0Mode == `ITC_MODE1) ? `ITC_MODE1_ADDR : {vectorHigh, 8'h00};
                next_table  = (level0Mode == `ITC_MODE2);
            end
            `ITC_SRC_LEVEL1: begin
                next_vector = {vectorHigh, vectorLowBase, `ITC_CODE_LEVEL1};
                next_table  = 1'b1;
            end
            `ITC_SRC_LEVEL2: begin
                next_vector = {vectorHigh, vectorLowBase, `ITC_CODE_LEVEL2};
                next_table  = 1'b1;
            end
            `ITC_SRC_NONE: begin
                next_vector = 16'h0000;
                next_table  = 1'b0;
            end
            default: begin
                // [RULE19] High byte from vector-high
                next_vector = {vectorHigh, vectorLowBase, chipCode};
                next_table  = 1'b1;
            end
        endcase
    end

    // Registered request to the sequencer
    // Accepted source is dropped at once so one strobe cannot retire two sources
    always @(posedge clk) begin
        if (rst) begin
            irqPending    <= 1'b0;
            irqSource     <= `ITC_SRC_NONE;
            vectorAddr    <= 16'h0000;
            vectorIsTable <= 1'b0;
        end else begin
            irqPending    <= (next_source != `ITC_SRC_NONE) && !acceptStrobe;
            irqSource     <= acceptStrobe ? `ITC_SRC_NONE : next_source;
            vectorAddr    <= next_vector;
            vectorIsTable <= next_table;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [RULE16] [RULE17] Trap sequencing
    // Trap outranks all sources; restart address is 0000H
    // Stacking the PC and the restart belong to the sequencer; this block only
    // flags the trap and marks the cycle that must not be stretched
    always @(posedge clk) begin
        if (rst) begin
            trapRequest  <= 1'b0;
            trap_state   <= 1'b0;
            trapNoInsert <= 1'b0;
        end else begin
            trapRequest  <= trapEvent;
            trap_state   <= trapRequest;
            trapNoInsert <= trapRequest;  // Blocks inserted cycles after trap state
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable flags
    wire acceptNmi      = acceptStrobe && irqSource == `ITC_SRC_NMI;
    wire acceptMaskable = acceptStrobe && irqSource >= `ITC_SRC_LEVEL0;

    // [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] Flag updates
    // Interrupt return and trap leave both flags untouched
    always @(posedge clk) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
            saved_irq_enable  <= 1'b0;
        end else if (acceptNmi) begin
            saved_irq_enable  <= global_irq_enable;
            global_irq_enable <= 1'b0;
        end else if (acceptMaskable || disable_interrupts_instr) begin
            global_irq_enable <= 1'b0;
            saved_irq_enable  <= 1'b0;
        end else if (enable_interrupts_instr) begin
            global_irq_enable <= 1'b1;
            saved_irq_enable  <= 1'b1;
        end else if (return_from_nonmaskable) begin
            global_irq_enable <= saved_irq_enable;
        end
    end

    // [RULE14] Enable state to parity/overflow, global flag taken
    // [RULE21] DMA main enable cleared on NMI acceptance
    always @(posedge clk) begin
        if (rst) begin
            parityFromEnable   <= 1'b0;
            parityStrobe       <= 1'b0;
            dmaMainEnableClear <= 1'b0;
        end else begin
            parityStrobe       <= load_acc_from_vector_high || load_acc_from_refresh;
            dmaMainEnableClear <= acceptNmi;
            if (load_acc_from_vector_high || load_acc_from_refresh)
                parityFromEnable <= global_irq_enable;
        end
    end

    // return_from_interrupt intentionally has no effect on the flags
    wire unusedReti = return_from_interrupt;

endmodule // itc_cpu_irq_trap
`default_nettype wire

// File: verif/itc_irq_trap_properties.sv
// Purpose: Concurrent checks on flag and trap outputs
// Assumes: Sequencer strobes are one-cycle pulses
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.vh"
module itc_irq_trap_properties (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Strobes and fetch reports
    input wire logic       enable_interrupts_instr,
    input wire logic       disable_interrupts_instr,
    input wire logic       return_from_nonmaskable,
    input wire logic       undefOpcode,
    input wire logic       ackLevel0Cycle,
    input wire logic       acceptStrobe,
    // Design outputs
    input wire logic       irqPending,
    input wire logic [3:0] irqSource,
    input wire logic       trapRequest,
    input wire logic       trap_state,
    input wire logic       trapNoInsert,
    input wire logic       dmaMainEnableClear,
    input wire logic       global_irq_enable,
    input wire logic       saved_irq_enable,
    input wire logic [1:0] level0Mode
);
    // Strobes that outrank a plain flag instruction
    wire calm   = !acceptStrobe && !disable_interrupts_instr;
    wire nmiAcc = acceptStrobe && irqSource == `ITC_SRC_NMI;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    property p_ei; enable_interrupts_instr && calm |=> global_irq_enable && saved_irq_enable; endproperty
    a_ei: assert property (p_ei) else $error("enable left a flag clear");
    property p_di; disable_interrupts_instr && !acceptStrobe |=> !global_irq_enable && !saved_irq_enable; endproperty
    a_di: assert property (p_di) else $error("disable left a flag set");
    property p_nmi; nmiAcc |=> !global_irq_enable && saved_irq_enable == $past(global_irq_enable); endproperty
    a_nmi: assert property (p_nmi) else $error("nmi accept flag copy wrong");
    property p_return_from_nonmaskable;
        return_from_nonmaskable && calm && !enable_interrupts_instr
            |=> global_irq_enable == $past(saved_irq_enable) && $stable(saved_irq_enable);
    endproperty
    a_return_from_nonmaskable: assert property (p_return_from_nonmaskable) else $error("nmi return restore wrong");
    property p_mask; acceptStrobe && irqSource >= `ITC_SRC_LEVEL0 |=> !global_irq_enable && !saved_irq_enable; endproperty
    a_mask: assert property (p_mask) else $error("maskable accept kept a flag");
    property p_trap; undefOpcode && !(ackLevel0Cycle && level0Mode != `ITC_MODE0) |=> trapRequest ##1 trap_state; endproperty
    a_trap: assert property (p_trap) else $error("trap sequence missing");
    property p_noins; trapNoInsert == trap_state; endproperty
    a_noins: assert property (p_noins) else $error("insert block not with trap state");
    property p_dma; nmiAcc |=> dmaMainEnableClear ##1 !dmaMainEnableClear; endproperty
    a_dma: assert property (p_dma) else $error("dma enable clear pulse wrong");
    property p_gate; irqPending && !global_irq_enable && !$past(global_irq_enable) |-> irqSource == `ITC_SRC_NMI; endproperty
    a_gate: assert property (p_gate) else $error("maskable source while disabled");
    // Main scenarios reached
    c_nmi: cover property (nmiAcc);
    c_trap: cover property (trap_state);
    c_mask: cover property (acceptStrobe && irqSource >= `ITC_SRC_LEVEL0);
endmodule // itc_irq_trap_properties
`default_nettype wire

// File: verif/itc_requester_model.sv
// Purpose: Interrupt requesters and acknowledging sequencer
// Assumes: Bench changes want and autoAccept at the falling edge
// Notes:   Request pins are active low
`timescale 1ns/1ps
`default_nettype none
module itc_requester_model (
    // Clock
    input  wire logic       clk,
    // Bench controls: nmi, level0, level1, level2
    input  wire logic [3:0] want,
    input  wire logic       autoAccept,
    // Design side
    input  wire logic       irqPending,
    output wire logic [3:0] reqPins_n,
    output var  logic       acceptStrobe
);
    assign reqPins_n = ~want;
    // One-cycle accept; a longer one would only hold the source at none and retire nothing more
    initial acceptStrobe = 1'b0;
    always @(negedge clk) begin
        acceptStrobe <= autoAccept && irqPending && !acceptStrobe;
    end
endmodule // itc_requester_model
`default_nettype wire

// File: verif/itc_cpu_irq_trap_tb.sv
// Purpose: Self-checking bench for the interrupt and trap block
// Assumes: Inputs change at the falling edge
// Notes:   Checker is bound after the module
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.vh"
module itc_cpu_irq_trap_tb;
    localparam A_VL = `ITC_ADDR_VECTOR_LOW;
    localparam A_CT = `ITC_ADDR_CONTROL;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] want = 4'h0;
    logic       autoAccept = 1'b0;
    logic [7:0] onchipReq = 8'h00;
    logic [7:0] ioAddr = 8'h00;
    logic [7:0] ioWrData = 8'h00;
    logic [1:0] ioOp = 2'h0;     // Write, read
    logic [7:0] ins = 8'h00;     // Instruction strobes
    logic [7:0] accData = 8'h00;
    logic [1:0] setMode = 2'h0;
    logic [2:0] fetch = 3'h0;    // Undefined, third byte, level-0 ack
    wire logic [3:0]  reqPins_n;
    wire logic [7:0]  ioRdData, vectorHigh;
    wire logic [3:0]  irqSource;
    wire logic [15:0] vectorAddr;
    wire logic [1:0]  level0Mode, flags, par;
    wire logic        acceptStrobe, irqPending, trapRequest, trap_state, tbl;
    int n_errors = 0;
    int tests_run = 0;
    itc_cpu_irq_trap dut (.clk, .rst, .onchipReq, .ioAddr, .ioWrData, .ioRdData, .accData, .setMode,
        .acceptStrobe, .irqPending, .irqSource, .vectorAddr, .trapRequest, .trap_state, .vectorHigh,
        .level0Mode, .nmiIn_n(reqPins_n[3]), .ext_irq_level0_n(reqPins_n[2]), .ext_irq_level1_n(reqPins_n[1]),
        .ext_irq_level2_n(reqPins_n[0]), .internal_io_write_instr(ioOp[1]), .internal_io_read_instr(ioOp[0]),
        .enable_interrupts_instr(ins[0]), .disable_interrupts_instr(ins[1]), .return_from_nonmaskable(ins[2]),
        .return_from_interrupt(ins[3]), .load_acc_from_vector_high(ins[4]), .load_acc_from_refresh(ins[5]),
        .loadVectorHigh(ins[6]), .setModeStrobe(ins[7]), .undefOpcode(fetch[2]), .undefThirdByte(fetch[1]),
        .ackLevel0Cycle(fetch[0]), .vectorIsTable(tbl), .trapNoInsert(), .parityStrobe(par[1]),
        .parityFromEnable(par[0]), .dmaMainEnableClear(), .global_irq_enable(flags[1]), .saved_irq_enable(flags[0]));
    itc_requester_model partner (.clk, .want, .autoAccept, .irqPending, .reqPins_n, .acceptStrobe);
    initial forever #4 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask
    // Register access, data held until the edge that takes it
    task automatic io(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        ioAddr = a;
        ioWrData = d;
        ioOp = op;
        @(negedge clk);
        ioOp = 2'h0;
    endtask
    task automatic pulse(input int k);
        @(negedge clk);
        ins[k] = 1'b1;
        @(negedge clk);
        ins = 8'h00;
    endtask
    task automatic trapTry(input logic [1:0] f, input logic exp);
        @(negedge clk);
        fetch = {1'b1, f};
        @(negedge clk);
        fetch = {1'b0, f};
        chk(trapRequest, exp);
    endtask
    // Bounded wait; running out ends the run
    task automatic waitPend(input logic lvl);
        int i;
        for (i = 0; i < 30 && irqPending !== lvl; i++) @(negedge clk);
        if (irqPending !== lvl) begin
            n_errors++;
            $display("MISMATCH at %0t: pending wait ran out", $time);
            tally_and_finish();
        end
    endtask
    task automatic take;
        autoAccept = 1'b1;
        waitPend(1'b0);
        autoAccept = 1'b0;
    endtask
    task automatic nmiShot;
        want = 4'h8;
        repeat (3) @(negedge clk);
        want = 4'h0;
        waitPend(1'b1);
        chk(irqSource, `ITC_SRC_NMI);
        chk(vectorAddr, `ITC_NMI_ADDR);
        take();
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        int m;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        io(2'b01, A_VL, 8'h00);
        chk(ioRdData, 8'h00);
        io(2'b01, A_CT, 8'h00);
        chk(ioRdData, 8'h01);
        chk({flags, vectorHigh, level0Mode}, 12'h000);
        io(2'b10, A_VL, 8'hff);
        io(2'b01, A_VL, 8'h00);
        chk(ioRdData, 8'he0);
        io(2'b01, 8'h35, 8'h00);
        chk(ioRdData, 8'h00);
        done("registers");
        trapTry(2'b10, 1'b1);
        io(2'b01, A_CT, 8'h00);
        chk(ioRdData, 8'hc1);
        io(2'b10, A_CT, 8'h80);
        io(2'b01, A_CT, 8'h00);
        chk(ioRdData, 8'hc0);
        io(2'b10, A_CT, 8'h01);
        io(2'b01, A_CT, 8'h00);
        chk(ioRdData, 8'h41);
        trapTry(2'b00, 1'b1);
        io(2'b01, A_CT, 8'h00);
        chk(ioRdData, 8'h81);
        for (m = 0; m < 3; m++) begin
            setMode = m[1:0];
            pulse(7);
            chk(level0Mode, m[1:0]);
        end
        trapTry(2'b01, 1'b0);
        setMode = 2'h0;
        pulse(7);
        trapTry(2'b01, 1'b1);
        done("trap and modes");
        pulse(0);
        chk(flags, 2'b11);
        trapTry(2'b00, 1'b1);
        pulse(3);
        chk(flags, 2'b11);
        pulse(4);
        chk(par, 2'b11);
        pulse(1);
        pulse(5);
        chk({par, flags}, 4'b1000);
        done("flags");
        accData = 8'h5a;
        pulse(6);
        chk(vectorHigh, 8'h5a);
        pulse(0);
        want = 4'h3;
        repeat (6) @(negedge clk);
        chk(irqPending, 1'b0);
        io(2'b10, A_CT, 8'h07);
        waitPend(1'b1);
        chk(irqSource, `ITC_SRC_LEVEL1);
        chk(vectorAddr, {8'h5a, 3'h7, `ITC_CODE_LEVEL1});
        chk(tbl, 1'b1);
        want = 4'h1;
        take();
        chk(flags, 2'b00);
        repeat (6) @(negedge clk);
        chk(irqPending, 1'b0);
        pulse(0);
        waitPend(1'b1);
        chk(vectorAddr, {8'h5a, 3'h7, `ITC_CODE_LEVEL2});
        want = 4'h0;
        take();
        repeat (4) @(negedge clk);
        onchipReq = 8'h01;
        pulse(0);
        waitPend(1'b1);
        chk(vectorAddr, 16'h5ae4);
        take();
        onchipReq = 8'h00;
        chk(flags, 2'b00);
        setMode = 2'h1;
        pulse(7);
        pulse(0);
        want = 4'h4;
        waitPend(1'b1);
        chk(irqSource, `ITC_SRC_LEVEL0);
        chk(vectorAddr, `ITC_MODE1_ADDR);
        chk(tbl, 1'b0);
        take();
        want = 4'h0;
        chk(flags, 2'b00);
        done("vectors");
        pulse(0);
        nmiShot();
        chk(flags, 2'b01);
        pulse(4);
        chk(par, 2'b10);
        pulse(2);
        chk(flags, 2'b11);
        pulse(1);
        nmiShot();
        chk(flags, 2'b00);
        pulse(2);
        chk(flags, 2'b00);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        io(2'b01, A_VL, 8'h00);
        chk({ioRdData, flags}, 10'h000);
        done("nmi and reset");
        tally_and_finish();
    end
endmodule // itc_cpu_irq_trap_tb
bind itc_cpu_irq_trap itc_irq_trap_properties u_props (.clk, .rst, .enable_interrupts_instr,
    .disable_interrupts_instr, .return_from_nonmaskable, .undefOpcode, .ackLevel0Cycle, .acceptStrobe,
    .irqPending, .irqSource, .trapRequest, .trap_state, .trapNoInsert, .dmaMainEnableClear,
    .global_irq_enable, .saved_irq_enable, .level0Mode);
`default_nettype wire
